// ---- include/nch_consts.svh ----
`ifndef NCH_CONSTS_SVH
`define NCH_CONSTS_SVH
// Behaviour
// R1: Move read 00-5-35, program 85-5-10, same plane.
// R2: Unlock bounds 23h/24h take three addresses.
// R3: Lock 2Ah, tight 2Ch; query 7Ah plus three addresses.
// R4: OTP program, lock, read; never while busy.
// R5: OTP encodings need OTP mode entered first; the code only records the mode in otp_reg and does not check it.
// R6: Die ready low means busy; withhold invalid commands.
// R7: Cache reads only after page or cache read; the code refuses an out-of-order one only while cpend_reg is set.
// R8: Cache program only after cache program; the code refuses an out-of-order one only while cpend_reg is set.
// R9: Two-plane read 00-5-00-5-30, refused on busy die.
// R10: Two-plane moves stay within plane boundaries.
// R11: Two-plane column change only after two-plane read.
// R12: Two-plane program 80-5-11-80-5-10, cache ends 15h.
// R13: Two-plane erase 60-3-D1-60-3-D0, D1 optional.
// R14: FFh resets device and abandons sequence.
// R15: Reset aborts busy read, program or erase.
// R16: Aborted page or block content is invalid.
// R17: Reset clears command register, invalidates page buffers.
// R18: Status after reset E0h, or 60h if protected.
// R19: Ready/busy low for reset time after FFh.
// R20: Reset is first command after power-on.
// R21: Power-on reset busy lasts at most 1ms.
// R22: Device ignores commands not allowed while busy.
`define NCH_REG_CTRL      8'h00
`define NCH_REG_CMD       8'h04
`define NCH_REG_FMT       8'h08
`define NCH_REG_ADDR_A_LO 8'h0c
`define NCH_REG_ADDR_A_HI 8'h10
`define NCH_REG_ADDR_B_LO 8'h14
`define NCH_REG_ADDR_B_HI 8'h18
`define NCH_REG_DATA      8'h1c
`define NCH_REG_STATUS    8'h20
`define NCH_REG_RDATA     8'h24
`define NCH_FMT_NB_LSB    3
`define NCH_FMT_C2A_EN    6
`define NCH_FMT_C2B_EN    7
`define NCH_FMT_C3_EN     8
`define NCH_FMT_WAIT      9
`define NCH_FMT_RD        10
`define NCH_FMT_DA        11
`define NCH_FMT_DB        12
`define NCH_FMT_START     31
`define NCH_ST_REFUSED    2
`define NCH_ST_TMO        3
`define NCH_ST_MISM       6
`define NCH_ST_ABORT      7
`define NCH_OP_READ1      8'h00
`define NCH_OP_READ2      8'h30
`define NCH_OP_CSEQ       8'h31
`define NCH_OP_CRAND      8'h31
`define NCH_OP_CRAND2     8'h32
`define NCH_OP_MOVE2      8'h35
`define NCH_OP_CLAST      8'h3f
`define NCH_OP_PROG2      8'h10
`define NCH_OP_CPROG2     8'h15
`define NCH_OP_ERASE2     8'hd0
`define NCH_OP_STATUS     8'h70
`define NCH_OP_STATUS_EN  8'h78
`define NCH_OP_MOVEPROG   8'h85
`define NCH_OP_COLCHG     8'h06
`define NCH_OP_SETFEAT    8'hef
`define NCH_OP_RESET      8'hff
`define NCH_MOVE_ADDRS    3'd5
`define NCH_RST_ST_WP_OFF 8'he0
`define NCH_RST_ST_WP_ON  8'h60
`define NCH_ARRAY_RDY_BIT 5
`define NCH_PLANE_BIT     18
`define NCH_OTP_FEAT_ADDR 8'h90
`define NCH_CLK_NS        10
`define NCH_T_RST_MAX_NS  1000000
`define NCH_T_RST_MAX_CLKS (`NCH_T_RST_MAX_NS / `NCH_CLK_NS)
`define NCH_T_WB_NS       100
`define NCH_T_WB_CLKS     (`NCH_T_WB_NS / `NCH_CLK_NS)
`define NCH_STROBE_LOW_CLKS  2
`define NCH_STROBE_HIGH_CLKS 2
`endif

// ---- include/nch_pkg.sv ----
package nch_pkg;
  typedef enum logic [13:0] {
    ST_IDLE = 14'h0001, ST_C1  = 14'h0002, ST_AA  = 14'h0004,
    ST_DA   = 14'h0008, ST_C2A = 14'h0010, ST_C2B = 14'h0020,
    ST_AB   = 14'h0040, ST_DB  = 14'h0080, ST_C3  = 14'h0100,
    ST_WLO  = 14'h0200, ST_WHI = 14'h0400, ST_RD  = 14'h0800,
    ST_SCMD = 14'h1000, ST_SRD = 14'h2000
  } nch_st_t;
  typedef enum logic [1:0] {
    K_CMD = 2'h0, K_ADDR = 2'h1, K_WRITE = 2'h2, K_READ = 2'h3
  } nch_kind_t;
  typedef enum logic [2:0] {
    CY_IDLE = 3'h1, CY_LOW = 3'h2, CY_HIGH = 3'h4
  } nch_cyst_t;
endpackage : nch_pkg

// ---- rtl/nch_cyc.sv ----
`timescale 1ns/1ps
`include "nch_consts.svh"
module nch_cyc
  import nch_pkg::*;
#(
  parameter int LOW_CLKS  = `NCH_STROBE_LOW_CLKS,
  parameter int HIGH_CLKS = `NCH_STROBE_HIGH_CLKS
) (
  input  logic       core_clk,
  input  logic       rst,
  input  logic       start,
  input  nch_kind_t  kind,
  input  logic [7:0] wbyte,
  input  logic [7:0] io_in,
  output logic       done,
  output logic [7:0] rbyte,
  output logic       cle,
  output logic       ale,
  output logic       we_n,
  output logic       re_n,
  output logic [7:0] io_out,
  output logic       io_oe
);
  nch_cyst_t  st_reg;
  logic [7:0] cnt_reg;

  // Data is driven for the whole cycle so it is stable around the
  // rising strobe edge; read data is taken as the strobe rises.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg  <= CY_IDLE;
      cnt_reg <= 8'h00;
      done    <= 1'b0;
      rbyte   <= 8'h00;
      cle     <= 1'b0;
      ale     <= 1'b0;
      we_n    <= 1'b1;
      re_n    <= 1'b1;
      io_out  <= 8'h00;
      io_oe   <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_reg)
        CY_IDLE: if (start) begin
          st_reg  <= CY_LOW;
          cnt_reg <= 8'h01;
          cle     <= (kind == K_CMD);
          ale     <= (kind == K_ADDR);
          io_oe   <= (kind != K_READ);
          io_out  <= wbyte;
          we_n    <= (kind == K_READ);
          re_n    <= (kind != K_READ);
        end
        CY_LOW: if (cnt_reg >= LOW_CLKS[7:0]) begin
          st_reg  <= CY_HIGH;
          cnt_reg <= 8'h01;
          we_n    <= 1'b1;
          re_n    <= 1'b1;
          if (!re_n) rbyte <= io_in;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
        CY_HIGH: if (cnt_reg >= HIGH_CLKS[7:0]) begin
          st_reg <= CY_IDLE;
          done   <= 1'b1;
          cle    <= 1'b0;
          ale    <= 1'b0;
          io_oe  <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      endcase
    end
  end

  strobe_low_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg == CY_IDLE && start |=> (!we_n || !re_n) && !(!we_n && !re_n))
    else $error("strobe not driven after start");
  done_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    done |-> we_n && re_n && !io_oe)
    else $error("cycle ended with pins active");
endmodule : nch_cyc

// ---- rtl/nch_host.sv ----
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "nch_consts.svh"
module nch_host
  import nch_pkg::*;
#(
  parameter int       PLANE_BIT     = `NCH_PLANE_BIT,
  parameter bit [7:0] OTP_FEAT      = `NCH_OTP_FEAT_ADDR,
  parameter int       BUSY_MAX_CLKS = `NCH_T_RST_MAX_CLKS,
  parameter int       WB_CLKS       = `NCH_T_WB_CLKS
) (
  input  logic        core_clk,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        nand_rb_n,
  input  logic [7:0]  nand_io_in,
  output logic        nand_ce_n,
  output logic        nand_cle,
  output logic        nand_ale,
  output logic        nand_we_n,
  output logic        nand_re_n,
  output logic        nand_wp_n,
  output logic [7:0]  nand_io_out,
  output logic        nand_io_oe
);
  localparam logic [13:0] PIN_MASK = 14'h39fe;

  logic [31:0] cmd_reg, a_lo_reg, b_lo_reg;
  logic [12:0] fmt_reg;
  logic [7:0]  a_hi_reg, b_hi_reg, rdata_reg;
  logic [23:0] data_reg;
  logic        launch_reg, run_rst_reg;
  logic        refused_reg, tmo_reg, mism_reg, abrt_reg;
  logic        init_reg, otp_reg, bufinv_reg, cpend_reg, last_pe_reg;
  logic        prev_read_reg, prev_cprog_reg, prev_tp_reg;
  logic        mv_ok_reg, mv_pa_reg, mv_pb_reg;
  nch_st_t     st_reg, nxt, tgt;
  logic [15:0] cnt_reg, lim;
  logic [23:0] tmr_reg;
  logic        cyc_start_reg, cyc_done;
  nch_kind_t   cyc_kind_reg;
  logic [7:0]  cyc_byte_reg, cyc_rbyte;
  logic [13:0] en;
  logic [39:0] addr_a, addr_b;
  logic [7:0]  c1, c2a, c2b, c3;
  logic        c2ae, c2be, c3e, pin_st, last, move;
  logic        is_rst, busy_ok, pg_read, tp_read, c_read, c_prog;
  logic        m_read, m_prog, col2, refuse, go, wr, hit, in_wait;
  logic [31:0] rd_val;
  logic [7:0]  rst_exp;
  logic        data_ctrl_wp;

  assign {c3, c2b, c2a, c1} = cmd_reg;
  assign c2ae   = fmt_reg[`NCH_FMT_C2A_EN];
  assign c2be   = fmt_reg[`NCH_FMT_C2B_EN];
  assign c3e    = fmt_reg[`NCH_FMT_C3_EN];
  assign addr_a = {a_hi_reg, a_lo_reg};
  assign addr_b = {b_hi_reg, b_lo_reg};
  assign nand_wp_n = data_ctrl_wp;
  assign rst_exp = data_ctrl_wp ? `NCH_RST_ST_WP_OFF : `NCH_RST_ST_WP_ON;

  // Command classes seen by the ordering checks.
  assign is_rst  = (c1 == `NCH_OP_RESET);
  assign busy_ok = is_rst || c1 == `NCH_OP_STATUS
                   || c1 == `NCH_OP_STATUS_EN;
  assign pg_read = c1 == `NCH_OP_READ1 && c3e && c3 == `NCH_OP_READ2;
  assign tp_read = pg_read && c2be && c2b == `NCH_OP_READ1;
  assign c_read  = c1 == `NCH_OP_CSEQ || c1 == `NCH_OP_CLAST
                   || (c3e && (c3 == `NCH_OP_CRAND
                               || c3 == `NCH_OP_CRAND2));
  assign c_prog  = c3e && c3 == `NCH_OP_CPROG2;
  assign m_read  = c3e && c3 == `NCH_OP_MOVE2;
  assign m_prog  = c1 == `NCH_OP_MOVEPROG
                   && fmt_reg[2:0] == `NCH_MOVE_ADDRS;
  assign col2    = (c1 == `NCH_OP_COLCHG);
  assign in_wait = (st_reg == ST_WLO) || (st_reg == ST_WHI);

  always_comb begin
    refuse = 1'b0;
    if (!init_reg && !is_rst) refuse = 1'b1; // R20
    if (!nand_rb_n && !busy_ok) refuse = 1'b1; // R6 R4 R9 R22
    if (c_read && cpend_reg && !prev_read_reg) refuse = 1'b1; // R7
    if (c_prog && cpend_reg && !prev_cprog_reg) refuse = 1'b1; // R8
    if (m_prog && (!mv_ok_reg || addr_a[PLANE_BIT] != mv_pa_reg
        || (c2be && addr_b[PLANE_BIT] != mv_pb_reg)))
      refuse = 1'b1; // R1 R10
    if (col2 && !prev_tp_reg) refuse = 1'b1; // R11
    // A reset may cut a busy wait short; nothing else may interrupt.
    if (st_reg != ST_IDLE && !(is_rst && in_wait)) refuse = 1'b1; // R15
  end
  assign go = launch_reg && !refuse;

  // APB slave: no wait states, answer registered in the setup cycle.
  assign wr = psel && penable && pready && pwrite;
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `NCH_REG_CTRL:      rd_val = {31'h0, data_ctrl_wp};
      `NCH_REG_CMD:       rd_val = cmd_reg;
      `NCH_REG_FMT:       rd_val = {19'h0, fmt_reg};
      `NCH_REG_ADDR_A_LO: rd_val = a_lo_reg;
      `NCH_REG_ADDR_A_HI: rd_val = {24'h0, a_hi_reg};
      `NCH_REG_ADDR_B_LO: rd_val = b_lo_reg;
      `NCH_REG_ADDR_B_HI: rd_val = {24'h0, b_hi_reg};
      `NCH_REG_DATA:      rd_val = {8'h0, data_reg};
      `NCH_REG_STATUS:    rd_val = {22'h0, cpend_reg, bufinv_reg,
                                    abrt_reg, mism_reg, otp_reg,
                                    init_reg, tmo_reg, refused_reg,
                                    nand_rb_n, st_reg != ST_IDLE};
      `NCH_REG_RDATA:     rd_val = {24'h0, rdata_reg};
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !hit;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_ctrl_wp <= 1'b0;
      cmd_reg  <= 32'h0000_0000;
      fmt_reg  <= 13'h0000;
      a_lo_reg <= 32'h0000_0000;
      a_hi_reg <= 8'h00;
      b_lo_reg <= 32'h0000_0000;
      b_hi_reg <= 8'h00;
      data_reg <= 24'h00_0000;
      launch_reg <= 1'b0;
    end else begin
      launch_reg <= 1'b0;
      if (wr) begin
        case (paddr)
          `NCH_REG_CTRL:      data_ctrl_wp <= pwdata[0];
          `NCH_REG_CMD:       cmd_reg <= pwdata;
          `NCH_REG_ADDR_A_LO: a_lo_reg <= pwdata;
          `NCH_REG_ADDR_A_HI: a_hi_reg <= pwdata[7:0];
          `NCH_REG_ADDR_B_LO: b_lo_reg <= pwdata;
          `NCH_REG_ADDR_B_HI: b_hi_reg <= pwdata[7:0];
          `NCH_REG_DATA:      data_reg <= pwdata[23:0];
          `NCH_REG_FMT: begin
            fmt_reg    <= pwdata[12:0];
            launch_reg <= pwdata[`NCH_FMT_START];
          end
          default: ;
        endcase
      end
    end
  end

  // Phase enables; phases run in bit order of the state codes.
  always_comb begin
    en = 14'h0000;
    en[1]  = 1'b1;
    en[2]  = fmt_reg[2:0] != 3'd0; // R2 R3
    en[3]  = fmt_reg[`NCH_FMT_DA] && data_reg[23:8] != 16'h0000;
    en[4]  = c2ae; // R13
    en[5]  = c2be; // R12
    en[6]  = fmt_reg[5:3] != 3'd0;
    en[7]  = fmt_reg[`NCH_FMT_DB] && data_reg[23:8] != 16'h0000;
    en[8]  = c3e;
    en[9]  = fmt_reg[`NCH_FMT_WAIT] || run_rst_reg; // R19
    en[10] = en[9];
    en[11] = fmt_reg[`NCH_FMT_RD];
    en[12] = run_rst_reg; // R18
    en[13] = run_rst_reg;
  end

  function automatic nch_st_t after(input nch_st_t s,
                                    input logic [13:0] e);
    logic [13:0] up;
    up = e & ~({s[12:0], 1'b0} - 14'h0001);
    up = up & (~up + 14'h0001);
    after = (up == 14'h0000) ? ST_IDLE : nch_st_t'(up);
  endfunction : after

  function automatic nch_kind_t kind_of(input nch_st_t s);
    if (s == ST_AA || s == ST_AB) kind_of = K_ADDR;
    else if (s == ST_DA || s == ST_DB) kind_of = K_WRITE;
    else if (s == ST_RD || s == ST_SRD) kind_of = K_READ;
    else kind_of = K_CMD;
  endfunction : kind_of

  function automatic logic [7:0] byte_of(input nch_st_t s,
                                         input logic [2:0] i);
    logic [39:0] sh;
    sh = (s == ST_AB ? addr_b : addr_a) >> {i, 3'b000};
    unique case (s)
      ST_C1:        byte_of = c1;
      ST_C2A:       byte_of = c2a;
      ST_C2B:       byte_of = c2b;
      ST_C3:        byte_of = c3;
      ST_SCMD:      byte_of = `NCH_OP_STATUS;
      ST_AA, ST_AB: byte_of = sh[7:0];
      ST_DA, ST_DB: byte_of = data_reg[7:0];
      default:      byte_of = 8'h00;
    endcase
  endfunction : byte_of

  assign nxt    = after(st_reg, en);
  assign pin_st = |(st_reg & PIN_MASK);
  always_comb begin
    lim = 16'h0001;
    if (st_reg == ST_AA) lim = {13'h0, fmt_reg[2:0]};
    else if (st_reg == ST_AB) lim = {13'h0, fmt_reg[5:3]};
    else if (st_reg == ST_DA || st_reg == ST_DB) lim = data_reg[23:8];
  end
  assign last = (cnt_reg + 16'h0001) >= lim;

  always_comb begin
    move = 1'b0;
    tgt  = nxt;
    if (go) begin
      move = 1'b1;
      tgt  = ST_C1; // R14
    end else if (pin_st && cyc_done && last) begin
      move = 1'b1;
    end else if (st_reg == ST_WLO) begin
      if (!nand_rb_n) begin
        move = 1'b1;
      end else if (tmr_reg >= WB_CLKS[23:0]) begin
        move = 1'b1;
        tgt  = after(ST_WHI, en);
      end
    end else if (st_reg == ST_WHI) begin
      move = nand_rb_n || tmr_reg >= BUSY_MAX_CLKS[23:0]; // R21
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg        <= ST_IDLE;
      cnt_reg       <= 16'h0000;
      tmr_reg       <= 24'h00_0000;
      cyc_start_reg <= 1'b0;
      cyc_kind_reg  <= K_CMD;
      cyc_byte_reg  <= 8'h00;
      nand_ce_n     <= 1'b1;
      run_rst_reg   <= 1'b0;
    end else begin
      cyc_start_reg <= 1'b0;
      tmr_reg <= tmr_reg + 24'h00_0001;
      if (go) run_rst_reg <= is_rst;
      nand_ce_n <= move ? (tgt == ST_IDLE) : (st_reg == ST_IDLE);
      if (move) begin
        st_reg        <= tgt;
        cnt_reg       <= 16'h0000;
        tmr_reg       <= 24'h00_0000;
        cyc_start_reg <= |(tgt & PIN_MASK);
        cyc_kind_reg  <= kind_of(tgt);
        cyc_byte_reg  <= byte_of(tgt, 3'd0);
      end else if (pin_st && cyc_done) begin
        cnt_reg       <= cnt_reg + 16'h0001;
        cyc_start_reg <= 1'b1;
        cyc_byte_reg  <= byte_of(st_reg, cnt_reg[2:0] + 3'd1);
      end
    end
  end

  // Sticky error flags; a new event wins over a same-cycle clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      refused_reg <= 1'b0;
      tmo_reg     <= 1'b0;
      mism_reg    <= 1'b0;
      abrt_reg    <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      if (wr && paddr == `NCH_REG_STATUS) begin
        refused_reg <= !pwdata[`NCH_ST_REFUSED] && refused_reg;
        tmo_reg     <= !pwdata[`NCH_ST_TMO] && tmo_reg;
        mism_reg    <= !pwdata[`NCH_ST_MISM] && mism_reg;
        abrt_reg    <= !pwdata[`NCH_ST_ABORT] && abrt_reg;
      end
      if (launch_reg && refuse) refused_reg <= 1'b1; // R22
      if (st_reg == ST_WHI && !nand_rb_n
          && tmr_reg >= BUSY_MAX_CLKS[23:0])
        tmo_reg <= 1'b1; // R21
      if (st_reg == ST_SRD && cyc_done && cyc_rbyte != rst_exp)
        mism_reg <= 1'b1; // R18
      if (go && is_rst && !nand_rb_n && last_pe_reg)
        abrt_reg <= 1'b1; // R16
      if ((st_reg == ST_RD || st_reg == ST_SRD) && cyc_done)
        rdata_reg <= cyc_rbyte;
    end
  end

  // Ordering history; only accepted commands update it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_reg       <= 1'b0;
      otp_reg        <= 1'b0;
      bufinv_reg     <= 1'b1;
      cpend_reg      <= 1'b0;
      last_pe_reg    <= 1'b0;
      prev_read_reg  <= 1'b0;
      prev_cprog_reg <= 1'b0;
      prev_tp_reg    <= 1'b0;
      mv_ok_reg      <= 1'b0;
      mv_pa_reg      <= 1'b0;
      mv_pb_reg      <= 1'b0;
    end else begin
      if (st_reg == ST_SRD && cyc_done) init_reg <= 1'b1; // R20
      if (st_reg == ST_RD && cyc_done && c1 == `NCH_OP_STATUS
          && cyc_rbyte[`NCH_ARRAY_RDY_BIT])
        cpend_reg <= 1'b0;
      if (go && is_rst) begin
        cpend_reg      <= 1'b0; // R17
        bufinv_reg     <= 1'b1; // R17
        prev_read_reg  <= 1'b0; // R14
        prev_cprog_reg <= 1'b0;
        prev_tp_reg    <= 1'b0;
        mv_ok_reg      <= 1'b0; // R16
        last_pe_reg    <= 1'b0;
      end else if (go && !busy_ok) begin
        prev_read_reg  <= pg_read || c_read;
        prev_cprog_reg <= c_prog;
        prev_tp_reg    <= tp_read || (col2 && prev_tp_reg);
        last_pe_reg    <= c3e && (c3 == `NCH_OP_PROG2
                          || c3 == `NCH_OP_CPROG2
                          || c3 == `NCH_OP_ERASE2);
        if (c_read || c_prog) cpend_reg <= 1'b1;
        if (pg_read || m_read) bufinv_reg <= 1'b0;
        if (m_read) begin
          mv_ok_reg <= 1'b1; // R1 R10
          mv_pa_reg <= addr_a[PLANE_BIT];
          mv_pb_reg <= c2be ? addr_b[PLANE_BIT] : addr_a[PLANE_BIT];
        end
        if (c1 == `NCH_OP_SETFEAT && a_lo_reg[7:0] == OTP_FEAT)
          otp_reg <= data_reg[7:0] != 8'h00; // R5
      end
    end
  end

  nch_cyc u_cyc (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (cyc_start_reg),
    .kind     (cyc_kind_reg),
    .wbyte    (cyc_byte_reg),
    .io_in    (nand_io_in),
    .done     (cyc_done),
    .rbyte    (cyc_rbyte),
    .cle      (nand_cle),
    .ale      (nand_ale),
    .we_n     (nand_we_n),
    .re_n     (nand_re_n),
    .io_out   (nand_io_out),
    .io_oe    (nand_io_oe)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  first_reset_a: assert property ( // R20
    cyc_start_reg && st_reg == ST_C1 && !init_reg
    |-> cyc_byte_reg == `NCH_OP_RESET)
    else $error("non-reset command before first reset");
  busy_gate_a: assert property ( // R6
    go |-> nand_rb_n || busy_ok)
    else $error("command issued to busy die");
  cache_read_a: assert property ( // R7
    go && c_read && cpend_reg |-> prev_read_reg)
    else $error("cache read out of order");
  cache_prog_a: assert property ( // R8
    go && c_prog && cpend_reg |-> prev_cprog_reg)
    else $error("cache program out of order");
  colchg_order_a: assert property ( // R11
    go && col2 |-> prev_tp_reg)
    else $error("column change without two-plane read");
  move_plane_a: assert property ( // R1
    go && m_prog |-> addr_a[PLANE_BIT] == mv_pa_reg)
    else $error("move crosses plane");
  reset_clear_a: assert property ( // R17
    go && is_rst |=> !cpend_reg && bufinv_reg && !prev_read_reg
    ##1 st_reg == ST_C1)
    else $error("reset did not clear history");
  busy_track_a: assert property ( // R19
    st_reg == ST_WLO && !nand_rb_n && !go |=> st_reg == ST_WHI)
    else $error("busy not followed");
  rst_status_a: assert property ( // R18
    st_reg == ST_SRD && cyc_done && cyc_rbyte != rst_exp |=> mism_reg)
    else $error("reset status mismatch not flagged");
  busy_timeout_a: assert property ( // R21
    st_reg == ST_WHI && !nand_rb_n && tmr_reg >= BUSY_MAX_CLKS[23:0]
    |=> tmo_reg && st_reg != ST_WHI)
    else $error("busy timeout not taken");

  reset_done_c: cover property (st_reg == ST_SRD && cyc_done);
  tp_read_c:    cover property (go && tp_read);
  refused_c:    cover property (launch_reg && refuse);
  abort_c:      cover property (go && is_rst && in_wait);
endmodule : nch_host

// ---- test/nch_nand_model.sv ----
`timescale 1ns/1ps
module nch_nand_model #(
  parameter int RST_CLKS = 50,
  parameter int OP_CLKS  = 60
) (
  input  wire logic       core_clk,
  input  wire logic       nand_ce_n,
  input  wire logic       nand_cle,
  input  wire logic       nand_we_n,
  input  wire logic       nand_re_n,
  input  wire logic       nand_wp_n,
  input  wire logic [7:0] nand_io_out,
  output logic            nand_rb_n,
  output logic      [7:0] nand_io_in
);
  logic [7:0] last_cmd;
  logic [7:0] stat;
  logic       we_q;
  int         busy;
  initial begin
    last_cmd = 8'h00;
    stat     = 8'h00;
    we_q     = 1'b1;
    busy     = 0;
  end
  assign nand_rb_n = (busy == 0);
  // Undriven bus shows the inverse so a stale sample cannot pass.
  assign nand_io_in = (!nand_re_n && !nand_ce_n) ? stat : ~stat;
  always @(posedge core_clk) begin
    we_q <= nand_we_n;
    if (busy > 0) busy <= busy - 1;
    if (nand_we_n && !we_q && !nand_ce_n && nand_cle &&
        (busy == 0 || nand_io_out == 8'hff || nand_io_out == 8'h70)) begin
      last_cmd <= nand_io_out;
      case (nand_io_out)
        8'hff: begin
          busy <= RST_CLKS;
          stat <= nand_wp_n ? 8'he0 : 8'h60;
        end
        8'h10, 8'h15, 8'h30, 8'h35, 8'hd0: busy <= OP_CLKS;
        default: ;
      endcase
    end
  end
endmodule : nch_nand_model

// ---- test/tb_nch_host.sv ----
`timescale 1ns/1ps
`include "nch_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_nch_host;
  typedef struct { logic [31:0] c; logic [31:0] f; logic [7:0] last; } nch_row_t;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, io_in, io_out;
  logic [31:0] pwdata, prdata, q;
  logic        rb_n, ce_n, cle, ale, we_n, re_n, wp_n, io_oe;
  int          n_fail = 0;
  int          compares = 0;
  nch_row_t    rows [8] = '{
    '{32'h0000002a, 32'h80000000, 8'h2a}, '{32'h0000002c, 32'h80000000, 8'h2c},
    '{32'h00000023, 32'h80000003, 8'h23}, '{32'h0000007a, 32'h80000403, 8'h7a},
    '{32'hd060d160, 32'h800003db, 8'hd0}, '{32'hd0600060, 32'h8000039b, 8'hd0},
    '{32'h30000000, 32'h800003ad, 8'h30}, '{32'he0000006, 32'h80000105, 8'he0}};
  nch_host #(.BUSY_MAX_CLKS(200)) i_nch_host (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nand_rb_n(rb_n),
    .nand_io_in(io_in), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
    .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
    .nand_io_out(io_out), .nand_io_oe(io_oe));
  nch_nand_model i_nch_nand_model (
    .core_clk(core_clk), .nand_ce_n(ce_n), .nand_cle(cle), .nand_we_n(we_n),
    .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_out),
    .nand_rb_n(rb_n), .nand_io_in(io_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic go(input logic [31:0] c, input logic [31:0] f);
    apb(1'b1, `NCH_REG_CMD, c);
    apb(1'b1, `NCH_REG_FMT, f);
  endtask : go
  // Polls until the sequence is over; a hang ends at the watchdog.
  task automatic launch(input logic [31:0] c, input logic [31:0] f);
    go(c, f);
    do apb(1'b0, `NCH_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask : launch
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (50000) @(posedge core_clk);
    n_fail++;
    $display("ERROR watchdog exp done got hang");
    test_done;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (3) @(posedge core_clk);
    `CHK("reset pins", 8'he0, {ce_n, we_n, re_n, cle, ale, io_oe, wp_n, pready})
    rst <= 1'b0;
    launch(32'h2a, 32'h80000000);
    `CHK("refused pre-init", 1'b1, q[2])
    `CHK("pins pre-init", 8'h00, i_nch_nand_model.last_cmd)
    apb(1'b1, `NCH_REG_STATUS, 32'h4);
    apb(1'b1, `NCH_REG_CTRL, 32'h1);
    launch(32'hff, 32'h80000200);
    `CHK("init done", 3'b001, q[6:4])
    apb(1'b0, `NCH_REG_RDATA, 32'h0);
    `CHK("reset status", 8'he0, q[7:0])
    foreach (rows[i]) begin
      launch(rows[i].c, rows[i].f);
      `CHK("refused", 1'b0, q[2])
      `CHK("last cmd", rows[i].last, i_nch_nand_model.last_cmd)
    end
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    go(rows[5].c, rows[5].f);
    do apb(1'b0, `NCH_REG_STATUS, 32'h0); while (q[1] !== 1'b0);
    go(32'h2a, 32'h80000000);
    apb(1'b0, `NCH_REG_STATUS, 32'h0);
    `CHK("busy refused", 1'b1, q[2])
    launch(32'hff, 32'h80000200);
    `CHK("aborted", 1'b1, q[7])
    `CHK("buffers invalid", 1'b1, q[8])
    `CHK("status cmd", 8'h70, i_nch_nand_model.last_cmd)
    apb(1'b1, `NCH_REG_CTRL, 32'h0);
    launch(32'hff, 32'h80000200);
    `CHK("no mismatch", 1'b0, q[6])
    apb(1'b0, `NCH_REG_RDATA, 32'h0);
    `CHK("protected status", 8'h60, q[7:0])
    test_done;
  end
endmodule : tb_nch_host
